// file: rtl/acc_conversion_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "acc_map.svh"

module acc_conversion_control
	import acc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        serial_clock,
	input  wire logic        frame_sync_n,
	input  wire logic        data_in,
	output var  acc_cfg_t    cfg_out,
	output var  acc_route_t  route_out,
	output var  logic        route_forbidden,
	output var  logic        ref_internal_on,
	output var  logic        core_powered,
	output var  logic        ref_powered,
	output var  logic        seq_enabled,
	output var  logic        seq_use_list,
	output var  logic        seq_consecutive,
	output var  logic [1:0]  seq_final_chan,
	output var  logic        cfg_update_pulse
);

	// =============================================
	// Link side: runs on the serial clock
	logic [4:0]               bit_cnt_ff;
	logic [`ACC_FRAME_LEN-2:0] shift_ff;
	logic                     cfg_write_ff;
	logic [`ACC_CFG_W-1:0]    link_word_ff;
	logic                     link_toggle_ff;
	logic                     pwr_toggle_ff;
	logic [`ACC_FRAME_LEN-2:0] nxt_shift;
	logic                     hdr_is_cfg;
	logic                     frame_rst_n;
	logic                     commit_now;

	assign nxt_shift  = {shift_ff[`ACC_FRAME_LEN-3:0], data_in};
	// Header is the first three bits, write flag leading
	assign hdr_is_cfg = shift_ff[2] && (shift_ff[1:0] == `ACC_SEL_CFG);

	// The serial clock stands still between frames, so frame_sync_n high cannot
	// wait for an edge to end a frame: it clears the frame state at once.
	// This keeps an aborted frame from leaving a stale count for the next one.
	assign frame_rst_n = rst_n && !frame_sync_n;

	// The fifteenth edge carries the last payload bit; the sixteenth is ignored
	assign commit_now = !frame_sync_n && (bit_cnt_ff == `ACC_PWR_EDGE) && cfg_write_ff;

	// Frame bit counter; saturates at sixteen so extra edges do nothing
	always_ff @(posedge serial_clock or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			bit_cnt_ff <= 5'h00;
		else if (bit_cnt_ff != `ACC_FRAME_LEN)
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
	end

	// Payload shifts in most significant bit first
	// Shifting stops after the sixteenth edge of a frame
	always_ff @(posedge serial_clock or negedge rst_n)
	begin
		if (!rst_n)
			shift_ff <= '0;
		else if (!frame_sync_n && bit_cnt_ff < `ACC_FRAME_LEN)
			shift_ff <= nxt_shift;
	end

	// Header decode latched once the three header bits are in
	always_ff @(posedge serial_clock or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			cfg_write_ff <= 1'b0;
		else if (bit_cnt_ff == 5'h03)
			cfg_write_ff <= hdr_is_cfg;
	end

	// Commit on the twelfth payload bit (15th edge); reserved bits stored as sent
	always_ff @(posedge serial_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_word_ff   <= `ACC_CFG_RESET;
			link_toggle_ff <= 1'b0;
		end
		else if (commit_now)
		begin
			link_word_ff   <= nxt_shift[`ACC_CFG_W-1:0];
			link_toggle_ff <= ~link_toggle_ff;
		end
	end

	// Power-down entry marker: 15th edge of the updating frame
	always_ff @(posedge serial_clock or negedge rst_n)
	begin
		if (!rst_n)
			pwr_toggle_ff <= 1'b0;
		else if (commit_now)
			pwr_toggle_ff <= ~pwr_toggle_ff;
	end

	// =============================================
	// Crossing into the system clock
	logic                  link_tog_s;
	logic                  seen_tog_ff;
	logic [`ACC_CFG_W-1:0] cfg_word_ff;
	logic                  new_word;

	acc_sync #(
		.W (1)
	) u_tog_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (link_toggle_ff),
		.sync_out (link_tog_s)
	);

	// Only the toggle bit crosses; the word waits on the link side, so two
	// commits must lie at least four system clocks apart to be taken apart.
	assign new_word = link_tog_s ^ seen_tog_ff;

	// Word is stable on the link side long before the synced toggle arrives
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen_tog_ff <= 1'b0;
			cfg_word_ff <= `ACC_CFG_RESET;
		end
		else
		begin
			seen_tog_ff <= link_tog_s;
			if (new_word)
				cfg_word_ff <= link_word_ff;
		end
	end

	// Pulse rises one clock before the decoded outputs change
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cfg_update_pulse <= 1'b0;
		else
			cfg_update_pulse <= new_word;
	end

	// =============================================
	// Field decode
	// Word bits 11 and 0 are reserved: stored as sent, never decoded
	acc_cfg_t nxt_cfg;

	always_comb
	begin
		nxt_cfg.chan_sel        = cfg_word_ff[`ACC_F_CHAN_HI:`ACC_F_CHAN_LO];
		nxt_cfg.pair_mode       = acc_pair_t'(cfg_word_ff[`ACC_F_PAIR_HI:`ACC_F_PAIR_LO]);
		nxt_cfg.power_mode      = acc_pm_t'(cfg_word_ff[`ACC_F_PWR_HI:`ACC_F_PWR_LO]);
		nxt_cfg.straight_binary = cfg_word_ff[`ACC_F_CODING];
		nxt_cfg.internal_ref    = cfg_word_ff[`ACC_F_REF];
		nxt_cfg.seq_mode        = acc_seq_t'(cfg_word_ff[`ACC_F_SEQ_HI:`ACC_F_SEQ_LO]);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cfg_out <= '0;
		else
			cfg_out <= nxt_cfg;
	end

	// =============================================
	// Channel routing
	// Both paired modes share one table; the one forbidden code is flagged,
	// not remapped, so the converter can refuse it
	acc_route_t nxt_route;

	always_comb
	begin
		nxt_route = '0;
		case (nxt_cfg.pair_mode)
			ACC_PAIR_PSEUDO3:
			begin
				nxt_route.pos_input = {1'b0, nxt_cfg.chan_sel};
				nxt_route.neg_input = 3'h3;
				nxt_route.forbidden = (nxt_cfg.chan_sel == `ACC_CHAN_FORBID);
			end
			ACC_PAIR_DIFF2, ACC_PAIR_PSEUDO2:
			begin
				nxt_route.pos_input = {1'b0, nxt_cfg.chan_sel[1], 1'b0};
				nxt_route.neg_input = {1'b0, nxt_cfg.chan_sel[1], 1'b1};
			end
			ACC_PAIR_SINGLE:
			begin
				nxt_route.pos_input = {1'b0, nxt_cfg.chan_sel};
				nxt_route.neg_input = `ACC_GND_CODE;
			end
			default:
			begin
				nxt_route = '0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			route_out       <= '0;
			route_forbidden <= 1'b0;
		end
		else
		begin
			route_out       <= nxt_route;
			route_forbidden <= nxt_route.forbidden;
		end
	end

	// =============================================
	// Sequencer mode decode
	// Final channel follows the channel field in every mode;
	// it only matters while consecutive sequencing is on
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq_enabled     <= 1'b0;
			seq_use_list    <= 1'b0;
			seq_consecutive <= 1'b0;
			seq_final_chan  <= 2'h0;
		end
		else
		begin
			seq_use_list    <= (nxt_cfg.seq_mode == ACC_SEQ_LIST);
			seq_consecutive <= (nxt_cfg.seq_mode == ACC_SEQ_CONSEC);
			seq_enabled     <= (nxt_cfg.seq_mode == ACC_SEQ_LIST)
				|| (nxt_cfg.seq_mode == ACC_SEQ_CONSEC);
			seq_final_chan  <= nxt_cfg.chan_sel;
		end
	end

	// =============================================
	// Power control
	// Auto modes take effect when the 15th-edge marker arrives; full shutdown and
	// normal follow the stored code directly.
	// Limitation: no wake-up is modelled; an auto mode stays down until a
	// new word with another power code lands.
	logic pwr_tog_s;
	logic pwr_seen_ff;
	logic auto_down_ff;

	acc_sync #(
		.W (1)
	) u_pwr_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (pwr_toggle_ff),
		.sync_out (pwr_tog_s)
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwr_seen_ff  <= 1'b0;
			auto_down_ff <= 1'b0;
		end
		else
		begin
			pwr_seen_ff <= pwr_tog_s;
			if (pwr_tog_s ^ pwr_seen_ff)
				auto_down_ff <= (link_word_ff[`ACC_F_PWR_HI:`ACC_F_PWR_LO]
					== ACC_PM_SHUTDOWN) || (link_word_ff[`ACC_F_PWR_HI:`ACC_F_PWR_LO]
					== ACC_PM_STANDBY);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_powered    <= 1'b1;
			ref_powered     <= 1'b1;
			ref_internal_on <= 1'b0;
		end
		else
		begin
			case (nxt_cfg.power_mode)
				ACC_PM_FULL_DOWN:
				begin
					core_powered <= 1'b0;
					ref_powered  <= 1'b0;
				end
				ACC_PM_SHUTDOWN:
				begin
					core_powered <= ~auto_down_ff;
					ref_powered  <= ~auto_down_ff;
				end
				ACC_PM_STANDBY:
				begin
					core_powered <= ~auto_down_ff;
					ref_powered  <= 1'b1;
				end
				ACC_PM_NORMAL:
				begin
					core_powered <= 1'b1;
					ref_powered  <= 1'b1;
				end
				default:
				begin
					core_powered <= 1'b1;
					ref_powered  <= 1'b1;
				end
			endcase
			// Uses the registered power flag, so it trails a power change by a clock
			ref_internal_on <= nxt_cfg.internal_ref && ref_powered;
		end
	end

endmodule

`default_nettype wire

// file: rtl/acc_map.svh
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// =============================================
// Frame layout
`define ACC_FRAME_LEN      5'd16
`define ACC_FRAME_LAST     5'd15
`define ACC_PWR_EDGE       5'd14
`define ACC_CFG_W          12
`define ACC_CFG_RESET      12'h000

// =============================================
// Field positions inside the 12-bit configuration word
`define ACC_F_ZERO_HI      11
`define ACC_F_CHAN_HI      10
`define ACC_F_CHAN_LO      9
`define ACC_F_PAIR_HI      8
`define ACC_F_PAIR_LO      7
`define ACC_F_PWR_HI       6
`define ACC_F_PWR_LO       5
`define ACC_F_CODING       4
`define ACC_F_REF          3
`define ACC_F_SEQ_HI       2
`define ACC_F_SEQ_LO       1
`define ACC_F_ZERO_LO      0

// =============================================
// Encodings
`define ACC_SEL_CFG        2'h0
`define ACC_CHAN_FORBID    2'h3
`define ACC_GND_CODE       3'h4

`endif

// file: rtl/acc_pkg.sv
package acc_pkg;

	typedef enum logic [1:0] {
		ACC_PM_NORMAL    = 2'h0,
		ACC_PM_STANDBY   = 2'h1,
		ACC_PM_SHUTDOWN  = 2'h2,
		ACC_PM_FULL_DOWN = 2'h3
	} acc_pm_t;

	typedef enum logic [1:0] {
		ACC_PAIR_SINGLE  = 2'h0,
		ACC_PAIR_PSEUDO2 = 2'h1,
		ACC_PAIR_DIFF2   = 2'h2,
		ACC_PAIR_PSEUDO3 = 2'h3
	} acc_pair_t;

	typedef enum logic [1:0] {
		ACC_SEQ_OFF0   = 2'h0,
		ACC_SEQ_LIST   = 2'h1,
		ACC_SEQ_CONSEC = 2'h2,
		ACC_SEQ_OFF3   = 2'h3
	} acc_seq_t;

	typedef struct packed {
		logic [1:0] chan_sel;
		acc_pair_t  pair_mode;
		acc_pm_t    power_mode;
		logic       straight_binary;
		logic       internal_ref;
		acc_seq_t   seq_mode;
	} acc_cfg_t;

	typedef struct packed {
		logic [2:0] pos_input;
		logic [2:0] neg_input;
		logic       forbidden;
	} acc_route_t;

endpackage

// file: rtl/acc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module acc_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

`default_nettype wire

// file: verif/acc_cc_properties.sv
`timescale 1ns/10ps
`default_nettype none

module acc_cc_properties
	import acc_pkg::*;
(
	input wire logic       clock,
	input wire logic       rst_n,
	input wire acc_cfg_t   cfg_out,
	input wire acc_route_t route_out,
	input wire logic       route_forbidden,
	input wire logic       ref_internal_on,
	input wire logic       core_powered,
	input wire logic       ref_powered,
	input wire logic       seq_enabled,
	input wire logic       seq_use_list,
	input wire logic       seq_consecutive,
	input wire logic [1:0] seq_final_chan,
	input wire logic       cfg_update_pulse
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ==========
	// Power state some cycles after a commit
	sequence s_dark(ref_on);
		!core_powered && ref_powered == ref_on;
	endsequence

	// Decoded outputs land one clock after the update pulse
	sequence s_new(acc_pm_t pm);
		cfg_update_pulse ##1 cfg_out.power_mode == pm;
	endsequence

	sequence s_landed(acc_pair_t pm);
		cfg_update_pulse ##1 cfg_out.pair_mode == pm;
	endsequence

	AST_ROUTE_SINGLE: assert property (
		s_landed(ACC_PAIR_SINGLE) |->
		route_out.pos_input == {1'b0, cfg_out.chan_sel} && route_out.neg_input == 3'h4)
		else $error("single route wrong");
	AST_ROUTE_FORBID: assert property (
		s_landed(ACC_PAIR_PSEUDO3) |->
		route_forbidden == (cfg_out.chan_sel == 2'h3) && route_out.neg_input == 3'h3)
		else $error("forbidden flag wrong");
	AST_ROUTE_PAIRS: assert property (
		cfg_update_pulse ##1 cfg_out.pair_mode inside {ACC_PAIR_DIFF2, ACC_PAIR_PSEUDO2} |->
		route_out.pos_input == {1'b0, cfg_out.chan_sel[1], 1'b0}
		&& route_out.neg_input == {1'b0, cfg_out.chan_sel[1], 1'b1})
		else $error("paired route wrong");
	AST_SEQ_DECODE: assert property (
		cfg_update_pulse |=> seq_use_list == (cfg_out.seq_mode == ACC_SEQ_LIST)
		&& seq_consecutive == (cfg_out.seq_mode == ACC_SEQ_CONSEC))
		else $error("sequencer decode wrong");
	AST_SEQ_FINAL: assert property (
		cfg_update_pulse |=> seq_final_chan == cfg_out.chan_sel
		&& seq_enabled == (cfg_out.seq_mode inside {ACC_SEQ_LIST, ACC_SEQ_CONSEC}))
		else $error("final channel wrong");
	AST_FULL_DOWN: assert property (
		s_new(ACC_PM_FULL_DOWN) |-> ##[0:3] s_dark(1'b0))
		else $error("full shutdown not reached");
	AST_SHUTDOWN: assert property (
		s_new(ACC_PM_SHUTDOWN) |-> ##[0:3] s_dark(1'b0))
		else $error("auto shutdown not reached");
	AST_STANDBY: assert property (
		s_new(ACC_PM_STANDBY) |-> ##[0:3] s_dark(1'b1))
		else $error("standby not reached");
	AST_NORMAL: assert property (
		s_new(ACC_PM_NORMAL) |-> ##[0:3] (core_powered && ref_powered))
		else $error("normal power not reached");
	AST_CFG_HOLD: assert property (
		$changed(cfg_out) |-> $past(cfg_update_pulse))
		else $error("config changed without commit");
endmodule

bind acc_conversion_control acc_cc_properties u_props (.clock, .rst_n, .cfg_out,
	.route_out, .route_forbidden, .ref_internal_on, .core_powered, .ref_powered,
	.seq_enabled, .seq_use_list, .seq_consecutive, .seq_final_chan, .cfg_update_pulse);

`default_nettype wire

// file: verif/acc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module acc_host_model
	import acc_pkg::*;
(
	output var logic serial_clock,
	output var logic frame_sync_n,
	output var logic data_in
);
	initial
	begin
		serial_clock = 1'b0;
		frame_sync_n = 1'b1;
		data_in = 1'b1;
	end

	// Clock stands low between frames; counts below 15 abort the frame
	task automatic send(input logic [15:0] frame, input int nbits);
		frame_sync_n = 1'b0;
		#7;
		for (int i = 15; i > 15 - nbits; i--)
		begin
			data_in = frame[i];
			#6;
			serial_clock = 1'b1;
			#6;
			serial_clock = 1'b0;
		end
		#5;
		frame_sync_n = 1'b1;
		data_in = ~data_in;
		#30;
	endtask

	task automatic write_cfg(input acc_cfg_t c);
		send({3'b100, 1'b0, c, 2'b00}, 16);
	endtask
endmodule

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import acc_pkg::*;
();
	logic       clock;
	logic       rst_n;
	logic       serial_clock, frame_sync_n, data_in;
	acc_cfg_t   cfg_out;
	acc_route_t route_out;
	logic       route_forbidden, ref_internal_on, core_powered, ref_powered;
	logic       seq_enabled, seq_use_list, seq_consecutive, cfg_update_pulse;
	logic [1:0] seq_final_chan;
	int         errors, checks_done, pulses;

	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	acc_host_model host (.serial_clock, .frame_sync_n, .data_in);
	acc_conversion_control dut (.clock, .rst_n, .serial_clock, .frame_sync_n, .data_in,
		.cfg_out, .route_out, .route_forbidden, .ref_internal_on, .core_powered,
		.ref_powered, .seq_enabled, .seq_use_list, .seq_consecutive, .seq_final_chan,
		.cfg_update_pulse);

	always @(posedge clock)
		if (cfg_update_pulse === 1'b1)
			pulses++;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========
	// One committed write, waiting for the pulse under a bound
	task automatic put(input acc_cfg_t c);
		int p;
		p = pulses;
		host.write_cfg(c);
		for (int i = 0; i < 30 && cfg_update_pulse !== 1'b1; i++)
			@(negedge clock);
		repeat (5) @(negedge clock);
		check("pulse count", 16'(pulses), 16'(p + 1));
	endtask

	initial
	begin
		acc_cfg_t c;
		int p;
		rst_n = 1'b0;
		errors = 0;
		checks_done = 0;
		pulses = 0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(negedge clock);
		check("cfg at reset", 16'(cfg_out), 16'h0000);
		check("power at reset", {14'h0, core_powered, ref_powered}, 16'h0003);
		p = pulses;
		host.send(16'h5ff0, 16);
		host.send(16'hbff0, 16);
		host.send(16'hfff0, 16);
		host.send(16'h9ff0, 14);
		repeat (12) @(negedge clock);
		check("cfg refused", 16'(cfg_out), 16'h0000);
		check("pulses refused", 16'(pulses), 16'(p));
		for (int k = 0; k < 16; k++)
		begin
			c = '{k[1:0], acc_pair_t'(k[3:2]), ACC_PM_NORMAL, k[0], k[1], acc_seq_t'(k[2:1])};
			put(c);
			check("cfg word", 16'(cfg_out), 16'(c));
			check("forbidden", {14'h0, route_forbidden, route_out.forbidden},
				{14'h0, {2{c.pair_mode == ACC_PAIR_PSEUDO3 && c.chan_sel == 2'h3}}});
			check("seq", {11'h0, seq_enabled, seq_use_list, seq_consecutive, seq_final_chan},
				{11'h0, c.seq_mode inside {ACC_SEQ_LIST, ACC_SEQ_CONSEC},
				c.seq_mode == ACC_SEQ_LIST, c.seq_mode == ACC_SEQ_CONSEC, c.chan_sel});
		end
		for (int m = 3; m >= 0; m--)
		begin
			c = '{2'h1, ACC_PAIR_SINGLE, acc_pm_t'(m[1:0]), m[1], m[0], ACC_SEQ_OFF0};
			put(c);
			check("power", {13'h0, core_powered, ref_powered, ref_internal_on},
				{13'h0, m == 0, m < 2, m[0] && m < 2});
			check("route", {10'h0, route_out.pos_input, route_out.neg_input}, 16'h000c);
		end
		print_verdict();
	end

	initial
	begin
		#100000;
		errors++;
		print_verdict();
	end
endmodule

`default_nettype wire
